// ### core/pgmc_top.sv
/*
 * general mask configuration register of an eight-channel power sourcing
 * controller, with the channel logic that its bits steer.
 * assumes an i2c engine outside that decodes frames into command, read and
 * write strobes, and event registers outside that report their bits here.
 */
`timescale 1ns/1ps
module pgmc_top #(
    parameter int MS_CYCLES_P = pgmc_pkg::MS_CYCLES
) (
    input  wire logic                                    sys_clk_i,
    input  wire logic                                    rst_n_i,
    input  wire logic [7:0]                              reg_cmd_i,
    input  wire logic                                    reg_wr_i,
    input  wire logic                                    reg_rd_i,
    input  wire logic [7:0]                              reg_wdata_i,
    output logic [7:0]                                   reg_rdata_o,
    output logic                                         reg_ack_o,
    output pgmc_pkg::pgmc_cfg_s                          cfg_o,
    input  wire logic [7:0]                              irq_event_i,
    input  wire logic [7:0]                              irq_mask_i,
    output logic                                         irq_n_o,
    input  wire logic [6:0]                              i2c_addr_i,
    input  wire logic [6:0]                              base_addr_i,
    output logic                                         addr_match_o,
    output logic                                         chan_group_o,
    output logic                                         word16_o,
    input  wire logic                                    fast_shutdown_input_i,
    input  wire logic [pgmc_pkg::PRIO_W-1:0]             fast_shutdown_code_i,
    input  wire logic [pgmc_pkg::NCH-1:0]                prio_1bit_i,
    input  wire logic [pgmc_pkg::NCH-1:0][pgmc_pkg::PRIO_W-1:0] prio_3bit_i,
    input  wire logic [7:0]                              overload_fault_ms_i,
    input  wire logic [7:0]                              current_limit_fault_ms_i,
    input  pgmc_pkg::pgmc_chan_in_s [pgmc_pkg::NCH-1:0]  chan_i,
    output pgmc_pkg::pgmc_chan_out_s [pgmc_pkg::NCH-1:0] chan_o
);
    import pgmc_pkg::*;

    // ------------------------------------------------------------------
    // general mask register and register port
    // ------------------------------------------------------------------
    logic [7:0] gm_reg;
    logic [7:0] gm_next;
    logic [7:0] rdata_reg;
    logic [7:0] rdata_next;
    logic       ack_reg;
    logic       ack_next;
    logic       hit;

    always_comb begin
        hit        = (reg_cmd_i == CMD_GEN_MASK);
        gm_next    = gm_reg;
        rdata_next = rdata_reg;
        ack_next   = 1'b0;
        if (hit && reg_wr_i) begin
            // reserved bits are stored so they read back as written
            gm_next  = reg_wdata_i;
            ack_next = 1'b1;
        end else if (hit && reg_rd_i) begin
            rdata_next = gm_reg;
            ack_next   = 1'b1;
        end else if (reg_rd_i) begin
            // other commands belong to neighbouring registers
            rdata_next = 8'h00;
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            // enable bit resets high, all others low
            gm_reg    <= GM_RESET;
            rdata_reg <= 8'h00;
            ack_reg   <= 1'b0;
        end else begin
            gm_reg    <= gm_next;
            rdata_reg <= rdata_next;
            ack_reg   <= ack_next;
        end
    end

    pgmc_cfg_s cfg;

    always_comb begin
        cfg.irq_output_enable           = gm_reg[GM_IRQ_EN_BIT];
        cfg.wide_access_select          = gm_reg[GM_WIDE_BIT];
        cfg.multi_level_priority_select = gm_reg[GM_MPRIO_BIT];
        cfg.class_change_only_enable    = gm_reg[GM_CLS_BIT];
        cfg.detect_change_only_enable   = gm_reg[GM_DET_BIT];
    end

    // ------------------------------------------------------------------
    // interrupt pin gating
    // ------------------------------------------------------------------
    logic irq_n_reg;
    logic irq_n_next;

    always_comb begin
        // enable low forces the pin inactive whatever the mask says
        // enable high: any unmasked event bit pulls the pin low
        // only the pin is gated; events are neither read nor cleared here
        irq_n_next = !(cfg.irq_output_enable && |(irq_event_i & ~irq_mask_i));
    end

    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            irq_n_reg <= 1'b1;
        end else begin
            irq_n_reg <= irq_n_next;
        end
    end

    // ------------------------------------------------------------------
    // slave address decode
    // ------------------------------------------------------------------
    logic match_reg;
    logic match_next;
    logic group_reg;
    logic group_next;
    logic word16_reg;
    logic word16_next;

    always_comb begin
        match_next  = 1'b0;
        group_next  = 1'b0;
        word16_next = cfg.wide_access_select;
        if (i2c_addr_i[6:1] != base_addr_i[6:1]) begin
            match_next = 1'b0;
        end else if (cfg.wide_access_select) begin
            // one address with A0 zero serves all eight channels
            match_next = (i2c_addr_i[0] == 1'b0);
        end else begin
            // two consecutive addresses, A0 selects channels 5-8
            match_next = 1'b1;
            group_next = i2c_addr_i[0];
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            match_reg  <= 1'b0;
            group_reg  <= 1'b0;
            word16_reg <= 1'b0;
        end else begin
            match_reg  <= match_next;
            group_reg  <= group_next;
            word16_reg <= word16_next;
        end
    end

    // ------------------------------------------------------------------
    // millisecond tick for the fault timers
    // ------------------------------------------------------------------
    logic [31:0] pre_reg;
    logic [31:0] pre_next;
    logic        tick;

    always_comb begin
        tick     = (pre_reg == 32'(MS_CYCLES_P - 1));
        pre_next = tick ? 32'h0 : pre_reg + 32'h1;
    end

    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pre_reg <= 32'h0;
        end else begin
            pre_reg <= pre_next;
        end
    end

    // ------------------------------------------------------------------
    // per-channel logic
    // ------------------------------------------------------------------
    genvar ch;
    generate
        for (ch = 0; ch < NCH; ch = ch + 1) begin : g_chan
            logic             ilim_flt;
            logic             ovld_flt;
            logic             det_flag;
            logic             cls_flag;
            logic [TMS_W-1:0] ovld_lim;
            logic             any_fault;
            logic             pg_reg;
            logic             pg_next;
            logic             pe_reg;
            logic             pe_next;
            logic             sd_reg;
            logic             sd_next;

            // 4-pair ports get the extra overload margin
            assign ovld_lim = {1'b0, overload_fault_ms_i} +
                              (chan_i[ch].four_pair ? OVLD_4P_EXTRA_MS : 9'h000);

            pgmc_fault_timer u_ilim (
                .sys_clk_i  (sys_clk_i),
                .rst_n_i    (rst_n_i),
                .tick_i     (tick),
                .active_i   (chan_i[ch].ilim_active),
                .limit_ms_i ({1'b0, current_limit_fault_ms_i}),
                .fault_o    (ilim_flt)
            );

            pgmc_fault_timer u_ovld (
                .sys_clk_i  (sys_clk_i),
                .rst_n_i    (rst_n_i),
                .tick_i     (tick),
                .active_i   (chan_i[ch].ovld_active),
                .limit_ms_i (ovld_lim),
                .fault_o    (ovld_flt)
            );

            pgmc_change_flag u_det (
                .sys_clk_i     (sys_clk_i),
                .rst_n_i       (rst_n_i),
                .done_i        (chan_i[ch].det_done),
                .result_i      (chan_i[ch].det_result),
                .only_change_i (cfg.detect_change_only_enable),
                .clr_i         (chan_i[ch].det_clr),
                .flag_o        (det_flag)
            );

            pgmc_change_flag u_cls (
                .sys_clk_i     (sys_clk_i),
                .rst_n_i       (rst_n_i),
                .done_i        (chan_i[ch].cls_done),
                .result_i      (chan_i[ch].cls_result),
                .only_change_i (cfg.class_change_only_enable),
                .clr_i         (chan_i[ch].cls_clr),
                .flag_o        (cls_flag)
            );

            always_comb begin
                any_fault = ilim_flt || ovld_flt ||
                            chan_i[ch].signature_dropout_fault ||
                            chan_i[ch].startup_fault;
                // a fault clears both flags, even against a set
                pg_next = any_fault ? 1'b0 : (pg_reg || chan_i[ch].pg_set);
                pe_next = any_fault ? 1'b0 : (pe_reg || chan_i[ch].pe_set);
                sd_next = 1'b0;
                if (cfg.multi_level_priority_select) begin
                    // priority from the three-bit table, code 0 means idle
                    sd_next = (fast_shutdown_code_i != '0) &&
                              (prio_3bit_i[ch] >= fast_shutdown_code_i);
                end else begin
                    sd_next = fast_shutdown_input_i && prio_1bit_i[ch];
                end
            end

            always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
                if (!rst_n_i) begin
                    pg_reg <= 1'b0;
                    pe_reg <= 1'b0;
                    sd_reg <= 1'b0;
                end else begin
                    pg_reg <= pg_next;
                    pe_reg <= pe_next;
                    sd_reg <= sd_next;
                end
            end

            assign chan_o[ch].power_good_flag     = pg_reg;
            assign chan_o[ch].power_enable_flag   = pe_reg;
            assign chan_o[ch].current_limit_fault = ilim_flt;
            assign chan_o[ch].overload_fault      = ovld_flt;
            assign chan_o[ch].detect_change_flag  = det_flag;
            assign chan_o[ch].class_change_flag   = cls_flag;
            assign chan_o[ch].shutdown            = sd_reg;
        end
    endgenerate

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    // priority select is bit 4 of the stored byte, reset zero
    assign cfg_o        = cfg;
    assign reg_rdata_o  = rdata_reg;
    assign reg_ack_o    = ack_reg;
    assign irq_n_o      = irq_n_reg;
    assign addr_match_o = match_reg;
    assign chan_group_o = group_reg;
    assign word16_o     = word16_reg;

endmodule

// ### core/pgmc_pkg.sv
/*
 * shared constants and carrier types of the general mask control block.
 * assumes a 100 mhz system clock and eight power channels.
 */
package pgmc_pkg;

    // ------------------------------------------------------------------
    // geometry
    // ------------------------------------------------------------------
    localparam int NCH    = 8;
    localparam int RES_W  = 4;
    localparam int PRIO_W = 3;
    localparam int TMS_W  = 9;

    // ------------------------------------------------------------------
    // register map and field layout
    // ------------------------------------------------------------------
    localparam logic [7:0] CMD_GEN_MASK = 8'h17;
    localparam logic [7:0] GM_RESET     = 8'h80;
    localparam int GM_IRQ_EN_BIT = 7;
    localparam int GM_WIDE_BIT   = 5;
    localparam int GM_MPRIO_BIT  = 4;
    localparam int GM_CLS_BIT    = 3;
    localparam int GM_DET_BIT    = 2;

    // ------------------------------------------------------------------
    // timing
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 10;
    localparam int MS_NS         = 1000000;
    localparam int MS_CYCLES     = MS_NS / CLK_PERIOD_NS;
    localparam logic [TMS_W-1:0] OVLD_4P_EXTRA_MS = 9'h006;

    // ------------------------------------------------------------------
    // types
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        TMR_IDLE = 2'b00,
        TMR_RUN  = 2'b01,
        TMR_EXP  = 2'b11
    } pgmc_tmr_e;

    typedef struct packed {
        logic irq_output_enable;
        logic wide_access_select;
        logic multi_level_priority_select;
        logic class_change_only_enable;
        logic detect_change_only_enable;
    } pgmc_cfg_s;

    typedef struct packed {
        logic             pg_set;
        logic             pe_set;
        logic             ilim_active;
        logic             ovld_active;
        logic             four_pair;
        logic             signature_dropout_fault;
        logic             startup_fault;
        logic             det_done;
        logic [RES_W-1:0] det_result;
        logic             det_clr;
        logic             cls_done;
        logic [RES_W-1:0] cls_result;
        logic             cls_clr;
    } pgmc_chan_in_s;

    typedef struct packed {
        logic power_good_flag;
        logic power_enable_flag;
        logic current_limit_fault;
        logic overload_fault;
        logic detect_change_flag;
        logic class_change_flag;
        logic shutdown;
    } pgmc_chan_out_s;

endpackage

// ### core/pgmc_fault_timer.sv
/*
 * one fault timer counting whole millisecond ticks while its fault is active.
 * assumes tick_i is a one-cycle pulse once per millisecond.
 */
`timescale 1ns/1ps
module pgmc_fault_timer (
    input  wire logic                       sys_clk_i,
    input  wire logic                       rst_n_i,
    input  wire logic                       tick_i,
    input  wire logic                       active_i,
    input  wire logic [pgmc_pkg::TMS_W-1:0] limit_ms_i,
    output logic                            fault_o
);
    import pgmc_pkg::*;

    pgmc_tmr_e          state_reg;
    pgmc_tmr_e          state_next;
    logic [TMS_W-1:0]   cnt_reg;
    logic [TMS_W-1:0]   cnt_next;
    logic               fault_reg;
    logic               fault_next;

    always_comb begin
        state_next = state_reg;
        cnt_next   = cnt_reg;
        fault_next = 1'b0;
        case (state_reg)
            TMR_IDLE: begin
                cnt_next = '0;
                if (active_i) begin
                    state_next = TMR_RUN;
                end
            end
            TMR_RUN: begin
                if (!active_i) begin
                    state_next = TMR_IDLE;
                end else if (tick_i) begin
                    // minimum timeout: the first tick may be partial, so wait limit+1
                    if (cnt_reg == limit_ms_i) begin
                        state_next = TMR_EXP;
                        fault_next = 1'b1;
                    end else begin
                        cnt_next = cnt_reg + 1'b1;
                    end
                end
            end
            TMR_EXP: begin
                if (!active_i) begin
                    state_next = TMR_IDLE;
                end
            end
            default: begin
                state_next = TMR_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_reg <= TMR_IDLE;
            cnt_reg   <= '0;
            fault_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            cnt_reg   <= cnt_next;
            fault_reg <= fault_next;
        end
    end

    assign fault_o = fault_reg;

endmodule

// ### core/pgmc_change_flag.sv
/*
 * one sticky change flag fed by a detection or classification result.
 * assumes done_i is a one-cycle pulse with result_i valid alongside.
 */
`timescale 1ns/1ps
module pgmc_change_flag (
    input  wire logic                       sys_clk_i,
    input  wire logic                       rst_n_i,
    input  wire logic                       done_i,
    input  wire logic [pgmc_pkg::RES_W-1:0] result_i,
    input  wire logic                       only_change_i,
    input  wire logic                       clr_i,
    output logic                            flag_o
);
    import pgmc_pkg::*;

    logic [RES_W-1:0] last_reg;
    logic [RES_W-1:0] last_next;
    logic             flag_reg;
    logic             flag_next;
    logic             set;

    always_comb begin
        set       = done_i && (!only_change_i || (result_i != last_reg));
        last_next = done_i ? result_i : last_reg;
        // set wins over a clear in the same cycle
        flag_next = set || (flag_reg && !clr_i);
    end

    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            last_reg <= '0;
            flag_reg <= 1'b0;
        end else begin
            last_reg <= last_next;
            flag_reg <= flag_next;
        end
    end

    assign flag_o = flag_reg;

endmodule

// ### bench/pgmc_host.sv
/*
 * host model: issues single-byte register reads and writes.
 * assumes the block acks one cycle after the strobe edge.
 */
`timescale 1ns/1ps
module pgmc_host (
    input  wire logic       sys_clk_i,
    input  wire logic [7:0] rdata_i,
    input  wire logic       ack_i,
    output logic [7:0]      cmd_o,
    output logic            wr_o,
    output logic            rd_o,
    output logic [7:0]      wdata_o
);
    initial {cmd_o, wr_o, rd_o, wdata_o} = '0;
    // ----------------------------------------------------------------
    // one transfer
    // ----------------------------------------------------------------
    // released command and data lines show the inverse so a stale value never matches; the strobes drop low
    task automatic xfer(input logic w, input logic [7:0] c, input logic [7:0] d,
                        output logic a, output logic [7:0] q);
        @(negedge sys_clk_i);
        cmd_o = c;
        wdata_o = d;
        wr_o = w;
        rd_o = !w;
        @(negedge sys_clk_i);
        a = ack_i;
        q = rdata_i;
        wr_o = 1'b0;
        rd_o = 1'b0;
        cmd_o = ~c;
        wdata_o = ~d;
    endtask
endmodule

// ### bench/pgmc_chk.sv
/*
 * checker of the general mask control block.
 * assumes it is bound into pgmc_top and sees only its ports.
 */
`timescale 1ns/1ps
module pgmc_chk
    import pgmc_pkg::*;
#(
    parameter int MS_CYCLES_P = 10
) (
    input  wire logic                       sys_clk_i,
    input  wire logic                       rst_n_i,
    input  wire logic [7:0]                 reg_cmd_i,
    input  wire logic                       reg_wr_i,
    input  wire logic                       reg_rd_i,
    input  wire logic [7:0]                 reg_wdata_i,
    input  wire logic                       reg_ack_o,
    input  pgmc_cfg_s                       cfg_o,
    input  wire logic [7:0]                 irq_event_i,
    input  wire logic [7:0]                 irq_mask_i,
    input  wire logic                       irq_n_o,
    input  wire logic [6:0]                 i2c_addr_i,
    input  wire logic                       addr_match_o,
    input  wire logic                       word16_o,
    input  wire logic                       fast_shutdown_input_i,
    input  wire logic [PRIO_W-1:0]          fast_shutdown_code_i,
    input  wire logic [NCH-1:0]             prio_1bit_i,
    input  wire logic [NCH-1:0][PRIO_W-1:0] prio_3bit_i,
    input  pgmc_chan_in_s [NCH-1:0]         chan_i,
    input  pgmc_chan_out_s [NCH-1:0]        chan_o
);
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!rst_n_i);
    wire hit = reg_cmd_i == CMD_GEN_MASK;
    chk_ack_hit: assert property ((reg_wr_i || reg_rd_i) && hit |=> reg_ack_o)
        else $error("no ack on mask access");
    chk_refused_cmd: assert property ((reg_wr_i || reg_rd_i) && !hit |=>
        !reg_ack_o && $stable(cfg_o)) else $error("foreign command took effect");
    chk_write_fields: assert property (reg_wr_i && hit |=>
        cfg_o == {$past(reg_wdata_i[7]), $past(reg_wdata_i[5:2])})
        else $error("written fields not applied");
    chk_irq_gate: assert property (rst_n_i |=> irq_n_o == !($past(cfg_o.irq_output_enable)
        && |$past(irq_event_i & ~irq_mask_i))) else $error("interrupt pin wrong");
    chk_word_mode: assert property (rst_n_i |=>
        word16_o == $past(cfg_o.wide_access_select)) else $error("access width wrong");
    chk_wide_odd: assert property (cfg_o.wide_access_select && i2c_addr_i[0]
        |=> !addr_match_o) else $error("odd address served in wide mode");
    chk_prio_one: assert property (!cfg_o.multi_level_priority_select |=>
        chan_o[0].shutdown == $past(fast_shutdown_input_i && prio_1bit_i[0]))
        else $error("one-bit shutdown wrong");
    chk_prio_three: assert property (cfg_o.multi_level_priority_select |=>
        chan_o[3].shutdown == $past(fast_shutdown_code_i != 0
        && prio_3bit_i[3] >= fast_shutdown_code_i)) else $error("three-bit shutdown wrong");
    chk_fault_clear: assert property (chan_i[0].startup_fault
        || chan_i[0].signature_dropout_fault |=> !chan_o[0].power_good_flag
        && !chan_o[0].power_enable_flag) else $error("power flags survive fault");
    chk_det_every: assert property (chan_i[0].det_done &&
        !cfg_o.detect_change_only_enable |=> chan_o[0].detect_change_flag)
        else $error("detect flag not set");
    chk_cls_every: assert property (chan_i[0].cls_done &&
        !cfg_o.class_change_only_enable |=> chan_o[0].class_change_flag)
        else $error("class flag not set");
    cov_ack: cover property (reg_ack_o);
    cov_irq: cover property (!irq_n_o);
    cov_current_limit_fault: cover property (chan_o[0].current_limit_fault);
endmodule
bind pgmc_top pgmc_chk #(.MS_CYCLES_P(MS_CYCLES_P)) u_chk (
    .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .reg_cmd_i(reg_cmd_i), .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i), .reg_wdata_i(reg_wdata_i), .reg_ack_o(reg_ack_o), .cfg_o(cfg_o),
    .irq_event_i(irq_event_i), .irq_mask_i(irq_mask_i), .irq_n_o(irq_n_o),
    .i2c_addr_i(i2c_addr_i), .addr_match_o(addr_match_o), .word16_o(word16_o),
    .fast_shutdown_input_i(fast_shutdown_input_i), .fast_shutdown_code_i(fast_shutdown_code_i),
    .prio_1bit_i(prio_1bit_i), .prio_3bit_i(prio_3bit_i), .chan_i(chan_i), .chan_o(chan_o));

// ### bench/testbench.sv
/*
 * self-checking bench of the general mask control block.
 * assumes the host model owns the register port; the bench drives the rest.
 */
`timescale 1ns/1ps
module testbench;
    import pgmc_pkg::*;
    logic                     sys_clk_i = 1'b0;
    logic                     rst_n_i = 1'b0;
    logic [7:0]               cmd, wd, q, rdata, ev, msk, p1, tov, tli;
    logic                     wr, rd, ack, dack, irq_n, match, grp, w16, fsi;
    logic [6:0]               addr;
    logic [2:0]               code;
    logic [NCH-1:0][2:0]      p3;
    pgmc_chan_in_s [NCH-1:0]  ci;
    pgmc_chan_out_s [NCH-1:0] co;
    pgmc_cfg_s                cfg;
    int                       fails = 0;
    int                       check_count = 0;
    wire [1:0]                dcf = {co[0].detect_change_flag, co[0].class_change_flag};
    wire [1:0]                pgf = {co[0].power_good_flag, co[0].power_enable_flag};
    always #5 sys_clk_i = ~sys_clk_i;
    // a short millisecond keeps the timer scenarios brief
    pgmc_top #(.MS_CYCLES_P(10)) DUT (
        .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .reg_cmd_i(cmd), .reg_wr_i(wr),
        .reg_rd_i(rd), .reg_wdata_i(wd), .reg_rdata_o(rdata), .reg_ack_o(dack),
        .cfg_o(cfg), .irq_event_i(ev), .irq_mask_i(msk), .irq_n_o(irq_n),
        .i2c_addr_i(addr), .base_addr_i(7'h20), .addr_match_o(match),
        .chan_group_o(grp), .word16_o(w16), .fast_shutdown_input_i(fsi),
        .fast_shutdown_code_i(code), .prio_1bit_i(p1), .prio_3bit_i(p3),
        .overload_fault_ms_i(tov), .current_limit_fault_ms_i(tli), .chan_i(ci), .chan_o(co));
    pgmc_host H (.sys_clk_i(sys_clk_i), .rdata_i(rdata), .ack_i(dack), .cmd_o(cmd),
        .wr_o(wr), .rd_o(rd), .wdata_o(wd));
    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic cyc(input int k);
        repeat (k) @(negedge sys_clk_i);
    endtask
    task automatic rw(input logic w, input logic [7:0] c, input logic [7:0] d);
        H.xfer(w, c, d, ack, q);
    endtask
    function automatic logic [7:0] sd();
        for (int i = 0; i < NCH; i++) sd[i] = co[i].shutdown;
    endfunction
    task automatic ev0(input logic dn, input logic cl, input logic [3:0] r);
        pgmc_chan_in_s s = ci[0];
        {ci[0].det_done, ci[0].cls_done, ci[0].det_clr, ci[0].cls_clr} = {dn, dn, cl, cl};
        {ci[0].det_result, ci[0].cls_result} = {r, r};
        cyc(1);
        ci[0] = s;
    endtask
    task automatic pw(input logic [3:0] v);
        pgmc_chan_in_s s = ci[0];
        {ci[0].pg_set, ci[0].pe_set, ci[0].signature_dropout_fault, ci[0].startup_fault} = v;
        cyc(1);
        ci[0] = s;
    endtask
    task automatic tmr(input logic [1:0] sel, input int lo, input int hi);
        int n = 0;
        {ci[0].ilim_active, ci[0].ovld_active} = sel;
        while (!(co[0].current_limit_fault | co[0].overload_fault) && n < 200) begin
            cyc(1);
            n++;
        end
        chk(n >= lo && n <= hi, 1'b1);
        cyc(1);
        {ci[0].ilim_active, ci[0].ovld_active} = 2'b00;
    endtask
    initial begin
        #300us;
        fails++;
        stop_test();
    end
    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        {ev, msk, p1, tov, tli, fsi, addr, code} = '0;
        p3 = '0;
        ci = '0;
        cyc(5);
        rst_n_i = 1'b1;
        rw(0, 8'h17, 8'h00);
        chk({ack, q}, 9'h180);
        chk(cfg, 5'h10);
        rw(1, 8'h17, 8'hff);
        chk(ack, 1'b1);
        rw(0, 8'h17, 8'h00);
        chk({q, cfg}, 13'h1fff);
        rw(1, 8'h17, 8'h43);
        rw(0, 8'h17, 8'h00);
        chk({q, cfg}, 13'h0860);
        rw(0, 8'h16, 8'h00);
        chk({ack, q}, 9'h000);
        rw(1, 8'h16, 8'hff);
        rw(0, 8'h17, 8'h00);
        chk(q, 8'h43);
        ev = 8'h01;
        cyc(1);
        chk(irq_n, 1'b1);
        rw(1, 8'h17, 8'h80);
        cyc(1);
        chk(irq_n, 1'b0);
        msk = 8'h01;
        cyc(1);
        chk(irq_n, 1'b1);
        msk = 8'h00;
        rw(1, 8'h17, 8'h00);
        cyc(1);
        chk(irq_n, 1'b1);
        rw(1, 8'h17, 8'h80);
        cyc(1);
        chk(irq_n, 1'b0);
        ev = 8'h00;
        addr = 7'h21;
        cyc(1);
        chk({match, grp, w16}, 3'b110);
        rw(1, 8'h17, 8'ha0);
        cyc(1);
        chk(match, 1'b0);
        addr = 7'h20;
        cyc(1);
        chk({match, grp, w16}, 3'b101);
        rw(1, 8'h17, 8'h80);
        {p1, fsi, code} = {8'h05, 1'b1, 3'h3};
        for (int i = 0; i < NCH; i++) p3[i] = 3'(i);
        cyc(1);
        chk(sd(), 8'h05);
        fsi = 1'b0;
        cyc(20000);
        chk(sd(), 8'h00);
        rw(1, 8'h17, 8'h90);
        cyc(1);
        chk(sd(), 8'hf8);
        code = 3'h0;
        cyc(1);
        chk(sd(), 8'h00);
        rw(1, 8'h17, 8'h8c);
        ev0(1, 0, 4'h0);
        chk(dcf, 2'b00);
        ev0(1, 0, 4'h5);
        chk(dcf, 2'b11);
        ev0(0, 1, 4'h0);
        ev0(1, 0, 4'h5);
        chk(dcf, 2'b00);
        rw(1, 8'h17, 8'h80);
        ev0(1, 0, 4'h5);
        chk(dcf, 2'b11);
        pw(4'hc);
        chk(pgf, 2'b11);
        pw(4'h2);
        chk(pgf, 2'b00);
        pw(4'hc);
        pw(4'h1);
        chk(pgf, 2'b00);
        {tli, tov} = {8'h02, 8'h01};
        pw(4'hc);
        tmr(2'b10, 20, 33);
        chk(pgf, 2'b00);
        ci[0].four_pair = 1'b1;
        tmr(2'b01, 70, 83);
        stop_test();
    end
endmodule
